// ==== hdl/uwc_host.sv ====
// Summary of operation
// - High-voltage increment 1 ends with up/down high before select returns.
// - High-voltage increment 2 and decrement 1 end with up/down low.
// - High-voltage decrement 2 with at least one step ends with up/down high before select returns.
// - After select returns high a new command may start at once.
// - Compatibility increment ends with up/down low, then select high promptly.
// - Standard decrement ends with up/down low, then select high promptly.
// - Compatibility decrement with at least one step ends with up/down high, then select high promptly.
`timescale 1ns/1ps

module uwc_host (
    input  wire logic            clock,
    input  wire logic            rst,
    input  wire logic            req_valid,
    input  wire uwc_pkg::uwc_req_t req,
    output logic                 req_ready,
    output logic                 done,
    output logic [5:0]           wiper_est,
    output uwc_pkg::uwc_pins_t   pins
);

    uwc_pkg::uwc_state_t state_q;
    uwc_pkg::uwc_cmd_t   cmd_q;
    logic [5:0]          left_q;
    logic [7:0]          tmr_q;
    logic                tmr_done;
    logic                done_q;
    logic [5:0]          wiper_q;
    logic                sel_n_q;
    logic                elev_q;
    logic                ud_q;
    logic                sel_go;
    logic                sel_back;
    logic                step_now;

    // Increment kind or decrement kind
    function automatic logic is_inc(input uwc_pkg::uwc_cmd_t c);
        return (c == uwc_pkg::UWC_CMD_INC) || (c == uwc_pkg::UWC_CMD_INC_C) ||
               (c == uwc_pkg::UWC_CMD_HV_INC1) || (c == uwc_pkg::UWC_CMD_HV_INC2);
    endfunction

    // Elevated select level marks the high-voltage commands
    function automatic logic is_hv(input uwc_pkg::uwc_cmd_t c);
        case (c)
            uwc_pkg::UWC_CMD_HV_INC1, uwc_pkg::UWC_CMD_HV_INC2,
            uwc_pkg::UWC_CMD_HV_DEC1, uwc_pkg::UWC_CMD_HV_DEC2: is_hv = 1'b1;
            default:                                            is_hv = 1'b0;
        endcase
    endfunction

    // Up/down level held while select returns high
    function automatic logic end_level(input uwc_pkg::uwc_cmd_t c);
        case (c)
            uwc_pkg::UWC_CMD_INC:     end_level = 1'b0;
            uwc_pkg::UWC_CMD_INC_C:   end_level = 1'b0;
            uwc_pkg::UWC_CMD_DEC:     end_level = 1'b0;
            uwc_pkg::UWC_CMD_DEC_C:   end_level = 1'b1;
            uwc_pkg::UWC_CMD_HV_INC1: end_level = 1'b1;
            uwc_pkg::UWC_CMD_HV_INC2: end_level = 1'b0;
            uwc_pkg::UWC_CMD_HV_DEC1: end_level = 1'b0;
            uwc_pkg::UWC_CMD_HV_DEC2: end_level = 1'b1;
            default:                  end_level = 1'b0;
        endcase
    endfunction

    assign tmr_done  = (tmr_q == 8'h00);
    assign req_ready = (state_q == uwc_pkg::UWC_IDLE);
    assign done      = done_q;
    assign wiper_est = wiper_q;
    assign sel_go    = (state_q == uwc_pkg::UWC_SETUD) && tmr_done;
    assign sel_back  = (state_q == uwc_pkg::UWC_END) && tmr_done;
    assign step_now  = (state_q == uwc_pkg::UWC_LOW) && tmr_done;
    assign pins      = '{select_low_n: sel_n_q, elevated_select_level: elev_q, up_down: ud_q};

    // Each phase lasts a fixed time so the pins meet setup and pulse widths
    always_ff @(posedge clock) begin
        if (rst) begin
            tmr_q <= 8'h00;
        end else if (state_q == uwc_pkg::UWC_IDLE || tmr_done) begin
            tmr_q <= uwc_pkg::PHASE_CYC - 8'h01;
        end else begin
            tmr_q <= tmr_q - 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= uwc_pkg::UWC_IDLE;
            cmd_q   <= uwc_pkg::UWC_CMD_INC;
            left_q  <= 6'h00;
        end else begin
            case (state_q)
                uwc_pkg::UWC_IDLE: begin
                    if (req_valid) begin
                        cmd_q   <= req.cmd;
                        left_q  <= req.steps;
                        state_q <= uwc_pkg::UWC_SETUD;
                    end
                end
                uwc_pkg::UWC_SETUD: begin
                    if (tmr_done) begin
                        state_q <= uwc_pkg::UWC_SEL;
                    end
                end
                uwc_pkg::UWC_SEL: begin
                    if (tmr_done) begin
                        state_q <= (left_q == 6'h00) ? uwc_pkg::UWC_END
                                 : (is_inc(cmd_q) ? uwc_pkg::UWC_LOW : uwc_pkg::UWC_HIGH);
                    end
                end
                uwc_pkg::UWC_HIGH: begin
                    if (tmr_done) begin
                        state_q <= (left_q == 6'h00) ? uwc_pkg::UWC_END : uwc_pkg::UWC_LOW;
                    end
                end
                uwc_pkg::UWC_LOW: begin
                    if (tmr_done) begin
                        left_q  <= left_q - 6'h01;
                        state_q <= uwc_pkg::UWC_HIGH;
                    end
                end
                uwc_pkg::UWC_END: begin
                    if (tmr_done) begin
                        state_q <= uwc_pkg::UWC_IDLE;
                    end
                end
                default: state_q <= uwc_pkg::UWC_IDLE;
            endcase
        end
    end

    // Select low level: all but the high-voltage commands
    always_ff @(posedge clock) begin
        if (rst) begin
            sel_n_q <= 1'b1;
        end else if (sel_go) begin
            sel_n_q <= is_hv(cmd_q);
        end else if (sel_back) begin
            sel_n_q <= 1'b1;
        end else if (state_q == uwc_pkg::UWC_IDLE) begin
            sel_n_q <= 1'b1;
        end
    end

    // Elevated flag stands in for the third select level
    always_ff @(posedge clock) begin
        if (rst) begin
            elev_q <= 1'b0;
        end else if (sel_go) begin
            elev_q <= is_hv(cmd_q);
        end else if (sel_back) begin
            elev_q <= 1'b0;
        end else if (state_q == uwc_pkg::UWC_IDLE) begin
            elev_q <= 1'b0;
        end
    end

    // Up/down is set a full phase before select leaves idle
    always_ff @(posedge clock) begin
        if (rst) begin
            ud_q <= 1'b0;
        end else begin
            case (state_q)
                uwc_pkg::UWC_IDLE: begin
                    if (req_valid) begin
                        ud_q <= is_inc(req.cmd);
                    end
                end
                uwc_pkg::UWC_SEL: begin
                    if (tmr_done && left_q == 6'h00) begin
                        // No steps: never raise the line here, a rise would move the wiper
                        ud_q <= end_level(cmd_q) & ud_q;
                    end else if (tmr_done) begin
                        ud_q <= 1'b0;
                    end
                end
                uwc_pkg::UWC_HIGH: begin
                    if (tmr_done) begin
                        ud_q <= (left_q == 6'h00) ? end_level(cmd_q) : 1'b0;
                    end
                end
                uwc_pkg::UWC_LOW: begin
                    if (tmr_done) begin
                        ud_q <= 1'b1; // Rising edge moves the wiper
                    end
                end
                default: ud_q <= ud_q;
            endcase
        end
    end

    // Device cannot be read back, so the host tracks the wiper itself
    always_ff @(posedge clock) begin
        if (rst) begin
            wiper_q <= uwc_pkg::WIPER_DEFAULT;
        end else if (step_now) begin
            if (is_inc(cmd_q) && wiper_q != uwc_pkg::WIPER_MAX) begin
                wiper_q <= wiper_q + 6'h01;
            end else if (!is_inc(cmd_q) && wiper_q != uwc_pkg::WIPER_MIN) begin
                wiper_q <= wiper_q - 6'h01;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= sel_back;
        end
    end

endmodule

// ==== hdl/uwc_pkg.sv ====
package uwc_pkg;

    localparam int unsigned WIPER_W       = 6;
    localparam logic [5:0]  WIPER_MAX     = 6'h3F;
    localparam logic [5:0]  WIPER_MIN     = 6'h00;
    localparam logic [5:0]  WIPER_DEFAULT = 6'h1F;
    localparam logic [5:0]  STEP_MAX      = 6'h3F;

    // Minimum phase time on the pins, in ns, and derived cycles at 200 MHz
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned PHASE_NS      = 500;
    localparam int unsigned PHASE_CYC_I   = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]  PHASE_CYC     = 8'(PHASE_CYC_I);

    // Command kinds, one per documented command
    typedef enum logic [2:0] {
        UWC_CMD_INC     = 3'h0,
        UWC_CMD_INC_C   = 3'h1,
        UWC_CMD_DEC     = 3'h2,
        UWC_CMD_DEC_C   = 3'h3,
        UWC_CMD_HV_INC1 = 3'h4,
        UWC_CMD_HV_INC2 = 3'h5,
        UWC_CMD_HV_DEC1 = 3'h6,
        UWC_CMD_HV_DEC2 = 3'h7
    } uwc_cmd_t;

    typedef struct packed {
        uwc_cmd_t   cmd;
        logic [5:0] steps;
    } uwc_req_t;

    typedef struct packed {
        logic select_low_n;
        logic elevated_select_level;
        logic up_down;
    } uwc_pins_t;

    typedef enum logic [5:0] {
        UWC_IDLE  = 6'b000001,
        UWC_SETUD = 6'b000010,
        UWC_SEL   = 6'b000100,
        UWC_HIGH  = 6'b001000,
        UWC_LOW   = 6'b010000,
        UWC_END   = 6'b100000
    } uwc_state_t;

endpackage

// ==== verif/uwc_checker.sv ====
`timescale 1ns/1ps
module uwc_checker (
    input wire logic               clock,
    input wire logic               rst,
    input wire logic               req_valid,
    input wire uwc_pkg::uwc_req_t  req,
    input wire logic               req_ready,
    input wire logic               done,
    input wire logic [5:0]         wiper_est,
    input wire uwc_pkg::uwc_pins_t pins
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic       act;
    logic       act_q;
    logic       inc_q;
    logic [2:0] cmd_q;
    logic       moved_q;
    assign act = !pins.select_low_n || pins.elevated_select_level;
    always_ff @(posedge clock) act_q <= act;
    always_ff @(posedge clock) if (act && !act_q) inc_q <= pins.up_down;
    always_ff @(posedge clock) if (req_valid && req_ready) cmd_q <= req.cmd;
    // Only a command that stepped has an end level to keep
    always_ff @(posedge clock) begin
        if (rst || (act && !act_q)) moved_q <= 1'b0;
        else if ($rose(pins.up_down) && act) moved_q <= 1'b1;
    end
    sequence sel_entry; act && !act_q; endsequence
    sequence sel_exit; !act && act_q; endsequence
    sequence up_step; $rose(pins.up_down) && act && inc_q; endsequence
    sequence dn_step; $rose(pins.up_down) && act && !inc_q; endsequence
    a_reset_default: assert property ($fell(rst) |-> wiper_est == 6'h1F && req_ready)
        else $error("bad reset value");
    a_single_level: assert property (pins.select_low_n || !pins.elevated_select_level)
        else $error("two select levels");
    a_entry_mode: assert property (sel_entry |->
        pins.up_down == !cmd_q[1] && pins.elevated_select_level == cmd_q[2])
        else $error("bad entry");
    a_inc_step: assert property (up_step |-> wiper_est ==
        ($past(wiper_est) == 6'h3F ? 6'h3F : $past(wiper_est) + 6'h01)) else $error("bad up");
    a_dec_step: assert property (dn_step |-> wiper_est ==
        ($past(wiper_est) == 6'h00 ? 6'h00 : $past(wiper_est) - 6'h01)) else $error("bad down");
    a_hold_idle: assert property (!$rose(pins.up_down) |-> $stable(wiper_est))
        else $error("wiper drift");
    a_end_level: assert property (sel_exit ##0 moved_q |->
        $past(pins.up_down) == (cmd_q inside {3'h3, 3'h4, 3'h7})) else $error("bad end level");
    a_done_after: assert property (sel_exit |-> done ##1 (!done && req_ready))
        else $error("bad done");
endmodule
bind uwc_host uwc_checker chk_u (.clock(clock), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .done(done), .wiper_est(wiper_est), .pins(pins));

// ==== verif/uwc_host_tb.sv ====
`timescale 1ns/1ps
module uwc_host_tb;
    logic               clock;
    logic               rst;
    logic               req_valid;
    uwc_pkg::uwc_req_t  req;
    logic               req_ready;
    logic               done;
    logic [5:0]         wiper_est;
    uwc_pkg::uwc_pins_t pins;
    logic [5:0]         pot;
    logic [5:0]         exp_q;
    int                 err_total;
    int                 n_compared;
    uwc_host dut_u (.clock(clock), .rst(rst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .done(done), .wiper_est(wiper_est), .pins(pins));
    uwc_pot_model pot_u (.rst(rst), .pins(pins), .wiper_q(pot));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic chk(input logic [5:0] got, input logic [5:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("compared %0d bad %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic send(input uwc_pkg::uwc_cmd_t c, input logic [5:0] n);
        int k;
        @(posedge clock);
        req_valid <= 1'b1;
        req <= '{cmd: c, steps: n};
        @(negedge clock);
        while (req_ready !== 1'b1) @(negedge clock);
        @(posedge clock);
        req_valid <= 1'b0;
        for (k = 0; k < n; k++)
            if (!c[1] && exp_q != 6'h3F) exp_q++;
            else if (c[1] && exp_q != 6'h00) exp_q--;
    endtask
    task automatic run(input uwc_pkg::uwc_cmd_t c, input logic [5:0] n);
        int k;
        send(c, n);
        for (k = 0; done !== 1'b1 && k < 14000; k++) @(negedge clock);
        if (k == 14000) err_total++;
        chk(wiper_est, exp_q);
        chk(pot, exp_q);
    endtask
    task automatic t_cmds();
        int i;
        for (i = 0; i < 8; i++)
            run(uwc_pkg::uwc_cmd_t'(i[2:0]), 6'h03);
        $display("commands done");
    endtask
    // No steps: select enters and leaves, and the wiper must not move
    task automatic t_zero();
        int i;
        for (i = 0; i < 8; i++)
            run(uwc_pkg::uwc_cmd_t'(i[2:0]), 6'h00);
        $display("zero steps done");
    endtask
    task automatic t_sat();
        run(uwc_pkg::UWC_CMD_INC_C, 6'h25);
        run(uwc_pkg::UWC_CMD_HV_INC2, 6'h02);
        run(uwc_pkg::UWC_CMD_HV_DEC1, 6'h3F);
        run(uwc_pkg::UWC_CMD_DEC_C, 6'h02);
        $display("saturation done");
    endtask
    // Reset in mid-command plays a brown-out
    task automatic t_brownout();
        send(uwc_pkg::UWC_CMD_DEC, 6'h05);
        repeat (500) @(posedge clock);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        exp_q = 6'h1F;
        @(negedge clock);
        chk(wiper_est, exp_q);
        chk(pot, exp_q);
        run(uwc_pkg::UWC_CMD_HV_DEC2, 6'h01);
        $display("brown-out done");
    endtask
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        exp_q = 6'h1F;
        err_total = 0;
        n_compared = 0;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        t_cmds();
        t_zero();
        t_sat();
        t_brownout();
        conclude();
    end
    // About 33k cycles expected; 80k allowed
    initial begin
        #400000;
        err_total++;
        conclude();
    end
endmodule

// ==== verif/uwc_pot_model.sv ====
`timescale 1ns/1ps
module uwc_pot_model (
    input wire logic               rst,
    input wire uwc_pkg::uwc_pins_t pins,
    output logic [5:0]             wiper_q
);
    logic inc_q;
    // No clock in the device: pin edges act directly
    always @(negedge pins.select_low_n or posedge pins.elevated_select_level)
        inc_q = pins.up_down;
    initial wiper_q = 6'h1F;
    // rst stands in for brown-out recovery; idle select ignores up/down
    always @(posedge rst or posedge pins.up_down) begin
        if (rst)
            wiper_q = 6'h1F;
        else if (!pins.select_low_n || pins.elevated_select_level) begin
            if (inc_q && wiper_q != 6'h3F)
                wiper_q = wiper_q + 6'h01;
            else if (!inc_q && wiper_q != 6'h00)
                wiper_q = wiper_q - 6'h01;
        end
    end
endmodule
